// >>> verilog/psp_consts.svh
// Register offsets, field positions, reset values and phase codes of the parallel slave port
`ifndef PSP_CONSTS_SVH
`define PSP_CONSTS_SVH

`define PSP_ADDR_DATA 8'h08
`define PSP_ADDR_STROBE 8'h09
`define PSP_ADDR_IRQ_FLAG 8'h0C
`define PSP_ADDR_DATA_DIR 8'h88
`define PSP_ADDR_CTRL 8'h89
`define PSP_ADDR_IRQ_EN 8'h8C

`define PSP_CTRL_IBF 7
`define PSP_CTRL_OBF 6
`define PSP_CTRL_INPUT_OVERFLOW_FLAG 5
`define PSP_CTRL_MODE 4
`define PSP_IRQ_BIT 7

`define PSP_PIN_RD 0
`define PSP_PIN_WR 1
`define PSP_PIN_CS 2

`define PSP_TRIS_RST 3'h7
`define PSP_TRIS_INPUT 3'h7
`define PSP_DATA_DIR_RST 8'hFF
`define PSP_BYTE_ZERO 8'h00
`define PSP_BYTE_ONES 8'hFF
`define PSP_STROBE_ZERO 3'h0

`define PSP_PH_Q1 2'h0
`define PSP_PH_Q2 2'h1
`define PSP_PH_Q3 2'h2
`define PSP_PH_Q4 2'h3
`define PSP_PH_STEP 2'h1

`endif

// >>> verilog/psp_pkg.sv
// Types of the parallel slave port
package psp_pkg;

  typedef enum logic [2:0] {
    PSP_IDLE   = 3'b000,
    PSP_WR_ACT = 3'b001,
    PSP_WR_Q2  = 3'b010,
    PSP_WR_Q4  = 3'b011,
    PSP_RD_ACT = 3'b100,
    PSP_RD_Q2  = 3'b101,
    PSP_RD_Q4  = 3'b110
  } psp_state_t;

  typedef struct packed {
    logic [7:0] d_sync1;
    logic [7:0] d_sync2;
    logic [2:0] e_sync1;
    logic [2:0] e_sync2;
    logic [7:0] d_snap;
    logic [2:0] e_snap;
    psp_state_t state;
    logic [7:0] wr_byte;
    logic [7:0] in_latch;
    logic [7:0] out_latch;
    logic [7:0] data_dir;
    logic [2:0] e_latch;
    logic [2:0] e_tris;
    logic mode;
    logic input_full_flag;
    logic output_full_flag;
    logic input_overflow_flag;
    logic irq_flag;
    logic irq_en;
    logic [7:0] rd_data;
    logic [7:0] d_out;
    logic [7:0] d_oe;
    logic [2:0] e_out;
    logic [2:0] e_oe;
    logic irq;
  } psp_regs_t;

endpackage

// >>> verilog/psp_qclk.sv
// Instruction-cycle phase generator: four clocks per cycle, Q1 to Q4
`timescale 1ns/10ps
`default_nettype none
`include "psp_consts.svh"

module psp_qclk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Phase strobes
  output logic q1,
  output logic q2,
  output logic q4
);

  logic [1:0] phase;
  logic [1:0] next_phase;

  always_comb begin
    next_phase = 2'(phase + `PSP_PH_STEP);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= `PSP_PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  assign q1 = (phase == `PSP_PH_Q1);
  assign q2 = (phase == `PSP_PH_Q2);
  assign q4 = (phase == `PSP_PH_Q4);

endmodule

`default_nettype wire

// >>> verilog/psp_port.sv
// Parallel slave port: data port, strobe port, control/status and interrupt flag
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "psp_consts.svh"

module psp_port (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RD_DATA,
  // Data port pins
  input wire logic [7:0] DATA_PIN_IN,
  output logic [7:0] DATA_PIN_OUT,
  output logic [7:0] DATA_PIN_OE,
  // Strobe port pins: read, write, chip select
  input wire logic [2:0] STROBE_PIN_IN,
  output logic [2:0] STROBE_PIN_OUT,
  output logic [2:0] STROBE_PIN_OE,
  // Interrupt request
  output logic PORT_IRQ
);

  psp_pkg::psp_regs_t s;
  psp_pkg::psp_regs_t next_s;

  logic q1;
  logic q2;
  logic q4;

  logic slave;
  logic selected;
  logic wr_low;
  logic rd_low;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  psp_qclk u_qclk (
    .clk(SYS_CLK),
    .rst(RST),
    .q1(q1),
    .q2(q2),
    .q4(q4)
  );

  // Strobes seen only after both sync stages
  always_comb begin
    slave = s.mode && (s.e_tris == `PSP_TRIS_INPUT);
    selected = slave && !s.e_sync2[`PSP_PIN_CS];
    wr_low = selected && !s.e_sync2[`PSP_PIN_WR];
    rd_low = selected && !s.e_sync2[`PSP_PIN_RD];
  end

  always_comb begin
    next_s = s;

    // Pin synchronisers
    next_s.d_sync1 = DATA_PIN_IN;
    next_s.d_sync2 = s.d_sync1;
    next_s.e_sync1 = STROBE_PIN_IN;
    next_s.e_sync2 = s.e_sync1;

    // Pin reads see the level valid at the start of the cycle
    if (q1) begin
      next_s.d_snap = s.d_sync2;
      next_s.e_snap = s.e_sync2;
    end

    // Read data stands for one cycle only
    next_s.rd_data = `PSP_BYTE_ZERO;

    // Firmware reads
    if (RD_STB) begin
      if (hit(ADDR, `PSP_ADDR_DATA)) begin
        if (slave) begin
          next_s.rd_data = s.in_latch;
          next_s.input_full_flag = 1'b0;
        end else begin
          next_s.rd_data = s.d_snap;
        end
      end else if (hit(ADDR, `PSP_ADDR_STROBE)) begin
        next_s.rd_data = {5'h00, s.e_snap};
      end else if (hit(ADDR, `PSP_ADDR_IRQ_FLAG)) begin
        next_s.rd_data = {s.irq_flag, 7'h00};
      end else if (hit(ADDR, `PSP_ADDR_IRQ_EN)) begin
        next_s.rd_data = {s.irq_en, 7'h00};
      end else if (hit(ADDR, `PSP_ADDR_DATA_DIR)) begin
        next_s.rd_data = s.data_dir;
      end else if (hit(ADDR, `PSP_ADDR_CTRL)) begin
        next_s.rd_data = {s.input_full_flag, s.output_full_flag, s.input_overflow_flag, s.mode, 1'b0, s.e_tris};
      end
    end

    // Firmware writes
    if (WR_STB) begin
      if (hit(ADDR, `PSP_ADDR_DATA)) begin
        next_s.out_latch = WR_DATA;
        if (slave) begin
          next_s.output_full_flag = 1'b1;
        end
      end else if (hit(ADDR, `PSP_ADDR_STROBE)) begin
        next_s.e_latch = WR_DATA[2:0];
      end else if (hit(ADDR, `PSP_ADDR_IRQ_FLAG)) begin
        next_s.irq_flag = WR_DATA[`PSP_IRQ_BIT];
      end else if (hit(ADDR, `PSP_ADDR_IRQ_EN)) begin
        next_s.irq_en = WR_DATA[`PSP_IRQ_BIT];
      end else if (hit(ADDR, `PSP_ADDR_DATA_DIR)) begin
        next_s.data_dir = WR_DATA;
      end else if (hit(ADDR, `PSP_ADDR_CTRL)) begin
        // Full flags are read only; overflow is cleared here
        next_s.input_overflow_flag = WR_DATA[`PSP_CTRL_INPUT_OVERFLOW_FLAG];
        next_s.mode = WR_DATA[`PSP_CTRL_MODE];
        next_s.e_tris = WR_DATA[2:0];
      end
    end

    // Transfer sequencer; runs after firmware so hardware sets win
    case (s.state)
      psp_pkg::PSP_IDLE: begin
        if (wr_low) begin
          next_s.state = psp_pkg::PSP_WR_ACT;
          next_s.wr_byte = s.d_sync2;
        end else if (rd_low) begin
          next_s.state = psp_pkg::PSP_RD_ACT;
          next_s.output_full_flag = 1'b0;
        end
      end
      psp_pkg::PSP_WR_ACT: begin
        if (wr_low) begin
          // Keep tracking the bus; the last byte before the rise is taken
          next_s.wr_byte = s.d_sync2;
        end else begin
          next_s.state = psp_pkg::PSP_WR_Q2;
        end
      end
      psp_pkg::PSP_WR_Q2: begin
        if (q2) begin
          next_s.state = psp_pkg::PSP_WR_Q4;
        end
      end
      psp_pkg::PSP_WR_Q4: begin
        if (q4) begin
          next_s.state = psp_pkg::PSP_IDLE;
          next_s.irq_flag = 1'b1;
          if (s.input_full_flag && next_s.input_full_flag) begin
            // Unread byte is kept; the newer one is dropped
            next_s.input_overflow_flag = 1'b1;
          end else begin
            next_s.in_latch = s.wr_byte;
            next_s.input_full_flag = 1'b1;
          end
        end
      end
      psp_pkg::PSP_RD_ACT: begin
        if (!rd_low) begin
          next_s.state = psp_pkg::PSP_RD_Q2;
        end
      end
      psp_pkg::PSP_RD_Q2: begin
        if (q2) begin
          next_s.state = psp_pkg::PSP_RD_Q4;
        end
      end
      psp_pkg::PSP_RD_Q4: begin
        if (q4) begin
          next_s.state = psp_pkg::PSP_IDLE;
          next_s.irq_flag = 1'b1;
        end
      end
      default: begin
        next_s.state = psp_pkg::PSP_IDLE;
      end
    endcase

    // Leaving slave mode drops any transfer; overflow is untouched
    if (!slave) begin
      next_s.state = psp_pkg::PSP_IDLE;
    end
    if (!s.mode) begin
      next_s.input_full_flag = 1'b0;
      next_s.output_full_flag = 1'b0;
    end

    // Data pins: external strobes own the direction in slave mode
    if (slave) begin
      next_s.d_out = next_s.out_latch;
      if (next_s.state == psp_pkg::PSP_RD_ACT) begin
        next_s.d_oe = `PSP_BYTE_ONES;
      end else begin
        next_s.d_oe = `PSP_BYTE_ZERO;
      end
    end else if (q4) begin
      // General purpose output changes at the end of the cycle
      next_s.d_out = next_s.out_latch;
      next_s.d_oe = ~next_s.data_dir;
    end else if (s.d_oe == `PSP_BYTE_ONES && s.mode) begin
      // Slave mode with strobes not yet inputs: a full drive set at Q4 is released on the next clock
      next_s.d_oe = `PSP_BYTE_ZERO;
    end

    // Strobe port pins follow their own direction bits
    if (q4) begin
      next_s.e_out = next_s.e_latch;
      next_s.e_oe = ~next_s.e_tris;
    end

    next_s.irq = next_s.irq_flag && next_s.irq_en;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s.d_sync1 <= `PSP_BYTE_ZERO;
      s.d_sync2 <= `PSP_BYTE_ZERO;
      s.e_sync1 <= `PSP_TRIS_RST;
      s.e_sync2 <= `PSP_TRIS_RST;
      s.d_snap <= `PSP_BYTE_ZERO;
      s.e_snap <= `PSP_STROBE_ZERO;
      s.state <= psp_pkg::PSP_IDLE;
      s.wr_byte <= `PSP_BYTE_ZERO;
      s.in_latch <= `PSP_BYTE_ZERO;
      s.out_latch <= `PSP_BYTE_ZERO;
      s.data_dir <= `PSP_DATA_DIR_RST;
      s.e_latch <= `PSP_STROBE_ZERO;
      s.e_tris <= `PSP_TRIS_RST;
      s.mode <= 1'b0;
      s.input_full_flag <= 1'b0;
      s.output_full_flag <= 1'b0;
      s.input_overflow_flag <= 1'b0;
      s.irq_flag <= 1'b0;
      s.irq_en <= 1'b0;
      s.rd_data <= `PSP_BYTE_ZERO;
      s.d_out <= `PSP_BYTE_ZERO;
      s.d_oe <= `PSP_BYTE_ZERO;
      s.e_out <= `PSP_STROBE_ZERO;
      s.e_oe <= `PSP_STROBE_ZERO;
      s.irq <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register
  assign RD_DATA = s.rd_data;
  assign DATA_PIN_OUT = s.d_out;
  assign DATA_PIN_OE = s.d_oe;
  assign STROBE_PIN_OUT = s.e_out;
  assign STROBE_PIN_OE = s.e_oe;
  assign PORT_IRQ = s.irq;

endmodule

`default_nettype wire

// >>> test/psp_port_assertions.sv
// Concurrent checks on the parallel slave port
`timescale 1ns/10ps
`default_nettype none
module psp_port_chk (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] RD_DATA,
  // Pins and interrupt
  input wire logic [7:0] DATA_PIN_OUT,
  input wire logic [7:0] DATA_PIN_OE,
  input wire logic [2:0] STROBE_PIN_IN,
  input wire logic [2:0] STROBE_PIN_OE,
  input wire logic PORT_IRQ
);
  logic mode;
  logic en;
  logic [2:0] dirs;
  logic [7:0] olat;
  wire slv = mode && dirs == 3'h7;
  wire rd_sel = !STROBE_PIN_IN[2] && !STROBE_PIN_IN[0];
  wire fw_irq = WR_STB && (ADDR == 8'h0C || ADDR == 8'h8C);
  default clocking dc @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // Shadow of firmware fields, rebuilt from the register writes
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mode <= 1'b0;
      en <= 1'b0;
      dirs <= 3'h7;
      olat <= 8'h00;
    end else if (WR_STB) begin
      if (ADDR == 8'h89) begin
        mode <= WR_DATA[4];
        dirs <= WR_DATA[2:0];
      end
      if (ADDR == 8'h8C) en <= WR_DATA[7];
      if (ADDR == 8'h08) olat <= WR_DATA;
    end
  end
  rd_idle_a:
    assert property (!$past(RD_STB) |-> RD_DATA == 8'h00) else $error("stray read data");
  flags_off_a:
    assert property (RD_STB && ADDR == 8'h89 && !mode && !$past(mode)
      |=> RD_DATA[7:6] == 2'b00) else $error("full flags set outside slave mode");
  oe_drive_a:
    assert property ((slv && rd_sel)[*6] |-> DATA_PIN_OE == 8'hFF) else $error("no read drive");
  oe_idle_a:
    assert property ((slv && !rd_sel)[*5] |-> DATA_PIN_OE == 8'h00) else $error("pins driven");
  out_val_a:
    assert property (slv && DATA_PIN_OE == 8'hFF && $stable(olat) |-> DATA_PIN_OUT == olat)
      else $error("wrong byte driven");
  irq_mask_a:
    assert property (!en && !$past(en) |-> !PORT_IRQ) else $error("masked irq seen");
  irq_sticky_a:
    assert property (PORT_IRQ && !fw_irq && !$past(fw_irq) |=> PORT_IRQ)
      else $error("irq dropped by itself");
  strb_dir_a:
    assert property ($stable(dirs)[*5] |-> STROBE_PIN_OE == ~dirs) else $error("strobe oe");
endmodule
bind psp_port psp_port_chk u_chk (.SYS_CLK, .RST, .ADDR, .WR_DATA, .WR_STB, .RD_STB,
  .RD_DATA, .DATA_PIN_OUT, .DATA_PIN_OE, .STROBE_PIN_IN, .STROBE_PIN_OE, .PORT_IRQ);
`default_nettype wire

// >>> test/psp_ext_cpu.sv
// External processor model on the slave port pins
`timescale 1ns/10ps
`default_nettype none
module psp_ext_cpu (
  // Clock
  input wire logic clk,
  // Device pin drive
  input wire logic [7:0] d_out,
  input wire logic [7:0] d_oe,
  input wire logic [2:0] s_out,
  input wire logic [2:0] s_oe,
  // Resolved pin levels
  output logic [7:0] d_in,
  output logic [2:0] s_in
);
  logic [7:0] drv = 8'h5A;
  logic [2:0] stb = 3'h7;
  // No pulls here: a released bus shows inverted junk, never a kind zero
  assign d_in = (d_oe & d_out) | (~d_oe & drv);
  assign s_in = (s_oe & s_out) | (~s_oe & stb);
  task automatic xfer(input logic wr, input logic [7:0] b, input int lo,
    output logic [7:0] got);
    @(posedge clk);
    drv <= wr ? b : ~drv;
    stb <= wr ? 3'h1 : 3'h2;
    repeat (lo) @(posedge clk);
    got = d_in;
    stb <= 3'h7;
    @(posedge clk);
    drv <= ~b;
    repeat (11) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> test/parallel_slave_port_tb.sv
// Self-checking testbench of the parallel slave port
`timescale 1ns/10ps
`default_nettype none
module parallel_slave_port_tb;
  logic SYS_CLK, RST, WR_STB, RD_STB, PORT_IRQ, was_rd;
  logic [7:0] ADDR, WR_DATA, RD_DATA, d_in, d_out, d_oe, b, got;
  logic [2:0] s_in, s_out, s_oe;
  logic [7:0] exp_q[$];
  int error_cnt, checks;
  psp_port u_dut (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .DATA_PIN_IN(d_in),
    .DATA_PIN_OUT(d_out), .DATA_PIN_OE(d_oe), .STROBE_PIN_IN(s_in),
    .STROBE_PIN_OUT(s_out), .STROBE_PIN_OE(s_oe), .PORT_IRQ(PORT_IRQ));
  psp_ext_cpu u_cpu (.clk(SYS_CLK), .d_out(d_out), .d_oe(d_oe), .s_out(s_out),
    .s_oe(s_oe), .d_in(d_in), .s_in(s_in));
  initial begin
    SYS_CLK = 1'b0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge SYS_CLK);
    WR_STB <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge SYS_CLK);
    exp_q.push_back(e);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge SYS_CLK);
    RD_STB <= 1'b0;
  endtask
  // Answer stands one cycle only, so it is compared at that cycle's end
  always @(posedge SYS_CLK) begin
    if (was_rd) check("read data", RD_DATA, exp_q.pop_front());
    was_rd <= RD_STB;
  end
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    RST = 1'b1;
    {ADDR, WR_DATA, WR_STB, RD_STB, was_rd} = '0;
    void'($urandom(96516));
    repeat (4) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd(8'h89, 8'h07);
    rd(8'h88, 8'hFF);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    wr(8'h89, 8'h17);
    wr(8'h8C, 8'h80);
    wr(8'h88, 8'h00);
    b = 8'($urandom());
    wr(8'h08, b);
    rd(8'h89, 8'h57);
    u_cpu.xfer(1'b0, 8'h00, 6 + $urandom_range(0, 6), got);
    check("external read", got, b);
    rd(8'h89, 8'h17);
    rd(8'h0C, 8'h80);
    check("irq line", {7'h00, PORT_IRQ}, 8'h01);
    wr(8'h0C, 8'h00);
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom());
      u_cpu.xfer(1'b1, b, 3 + i, got);
      rd(8'h89, 8'h97);
      rd(8'h08, b);
      rd(8'h89, 8'h17);
    end
    rd(8'h0C, 8'h80);
    u_cpu.xfer(1'b1, b, 3, got);
    u_cpu.xfer(1'b1, ~b, 3, got);
    rd(8'h89, 8'hB7);
    rd(8'h08, b);
    rd(8'h89, 8'h37);
    wr(8'h89, 8'h17);
    wr(8'h8C, 8'h00);
    u_cpu.xfer(1'b1, b, 4, got);
    check("masked irq", {7'h00, PORT_IRQ}, 8'h00);
    wr(8'h89, 8'h07);
    rd(8'h89, 8'h07);
    wr(8'h89, 8'h00);
    wr(8'h09, 8'h05);
    wr(8'h08, 8'hC3);
    // Pin outputs wait for Q4, snapshots for the next Q1 after sync
    repeat (12) @(posedge SYS_CLK);
    check("strobe pins", {5'h00, s_out}, 8'h05);
    check("data pins", d_out, 8'hC3);
    rd(8'h09, 8'h05);
    rd(8'h08, 8'hC3);
    check("strobe enables", {5'h00, s_oe}, 8'h07);
    repeat (2) @(posedge SYS_CLK);
    tally_and_finish();
  end
endmodule
`default_nettype wire
